// ==== oprc_pkg.sv ====
// Package for the on-off keyed pulse-width remote codec: timing, framing and code constants.
// Assumes a 200 MHz ref_clk; all counts are derived from times in ns.
package oprc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	// Bit period of the keyed carrier
	// Kept short so that a whole frame fits a practical run; a bit rate of about 66 kHz lies well above the 20 kHz edge limit
	localparam int unsigned BIT_PERIOD_NS = 15000;
	localparam int unsigned BIT_CYC       = BIT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned THIRD_CYC     = BIT_CYC / 3;
	localparam int unsigned TWO_THIRD_CYC = BIT_CYC - THIRD_CYC;
	// Long/short split for a received high pulse: half a bit period
	localparam int unsigned SPLIT_CYC     = BIT_CYC / 2;
	// Pulses shorter than this are treated as noise
	localparam int unsigned MIN_PULSE_NS  = 1250;
	localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Pulses longer than a bit period are noise too
	localparam int unsigned MAX_PULSE_CYC = BIT_CYC;
	localparam int unsigned TMR_W         = 18;

	localparam logic [15:0] PREAMBLE      = 16'hFFFE;
	localparam logic [7:0]  PRE_LOW       = 8'hFE;
	localparam logic [3:0]  BTN0_CODE     = 4'h1;
	localparam logic [3:0]  BTN1_CODE     = 4'h3;
	localparam logic [3:0]  BTN2_CODE     = 4'h7;
	localparam logic [3:0]  BTN3_CODE     = 4'hF;
	localparam logic [3:0]  BATT_OK       = 4'h0;
	localparam logic [3:0]  BATT_LOW      = 4'hF;
	localparam logic [2:0]  DATA_REPEATS  = 3'h3;
	localparam logic [4:0]  FRAME_BITS    = 5'h10;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;

	// Button index to identity nibble
	function automatic logic [3:0] oprc_btn_code(input logic [1:0] idx);
		case (idx)
			2'h0:    oprc_btn_code = BTN0_CODE;
			2'h1:    oprc_btn_code = BTN1_CODE;
			2'h2:    oprc_btn_code = BTN2_CODE;
			default: oprc_btn_code = BTN3_CODE;
		endcase
	endfunction
endpackage

// ==== oprc_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input level; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module oprc_sync
	import oprc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic rst_val,
	input  wire logic din,
	output var  logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} oprc_sync_t;

	oprc_sync_t st_q;
	oprc_sync_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.out = st_q.s3;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= {4{rst_val}};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.out;
endmodule
`default_nettype wire

// ==== oprc_bit_timer.sv ====
// Bit timer: loads an interval and pulses done when it runs out.
// Assumes the loader gives a nonzero count; load wins over a running count.
`timescale 1ns/1ps
`default_nettype none
module oprc_bit_timer
	import oprc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] count,
	output var  logic             done
);
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             done;
	} oprc_tmr_t;

	oprc_tmr_t st_q;
	oprc_tmr_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (load) begin
			st_d.cnt = count - TMR_W'(1);
			st_d.run = 1'b1;
		end else if (st_q.run) begin
			if (st_q.cnt == '0) begin
				st_d.run = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;
endmodule
`default_nettype wire

// ==== oprc_codec.sv ====
// Top of the on-off keyed pulse-width remote codec: transmit encoder and receive decoder.
// Assumes active-low buttons, a demodulated data line and a strength comparator, all asynchronous.
// Overview of operation
// R1 - A one keys carrier on for two-thirds of the bit, off one-third.
// R2 - A zero keys carrier on for one-third of the bit, off two-thirds.
// R3 - Each message starts with preamble FFFE, then the data byte.
// R4 - Data byte: battery status upper nibble, button identity lower nibble.
// R5 - The data byte is sent three times after the preamble.
// R6 - Battery nibble zero means supply fine; any other value means low. The receiver takes only F as low.
// R7 - Button codes are 0001, 0011, 0111 and 1111 for buttons zero to three.
// R8 - One bit: carrier on, load two-thirds; on expiry off, load one-third.
// R9 - Zero bit: carrier on, load one-third; on expiry off, load two-thirds.
// R10 - Low-battery input is sampled at each press and put in the message; the code samples it only at a press that wakes the sender from sleep.
// R11 - Sender wakes from sleep when a button input falls high to low.
// R12 - Receiver always listens and checks every edge on the data input.
// R13 - Edge timer counts up from zero until a data edge stops it.
// R14 - Timer restarts on each edge; only falling edges give pulse length.
// R15 - Long high pulse decodes as one, short as zero.
// R16 - Bits shift into a register matched against preamble low byte.
// R17 - After preamble, the next eight bits form the candidate data byte.
// R18 - Candidate checked against four codes; mismatch clears and restarts search.
// R19 - Two indicators show button number in binary on a valid code.
// R20 - Low-battery indicator lights together with the button display.
// R21 - Optionally, edges without strong signal strength are discarded.
// R22 - The carrier is simply keyed on and off, width carrying the value.
// R23 - Bytes go most significant bit first on both sides.
`timescale 1ns/1ps
`default_nettype none
module oprc_codec
	import oprc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic [3:0] button_n,
	input  wire logic       low_batt,
	input  wire logic       rx_data,
	input  wire logic       signal_strength_indicator,
	input  wire logic       strength_check_en,
	output var  logic       carrier_on,
	output var  logic       tx_asleep,
	output var  logic       led_first,
	output var  logic       led_second,
	output var  logic       led_low_batt,
	output var  logic       code_valid
);
	typedef enum logic [1:0] {
		TX_SLEEP = 2'h0,
		TX_HIGH  = 2'h1,
		TX_LOW   = 2'h3,
		TX_NEXT  = 2'h2
	} oprc_tx_state_t;

	typedef struct packed {
		oprc_tx_state_t   tx_st;
		logic [23:0]      frame;
		logic [4:0]       bits_left;
		logic [2:0]       reps_left;
		logic [7:0]       data_byte;
		logic             cur_bit;
		logic [3:0]       btn_prev;
		logic             carrier;
		logic             asleep;
		logic             rx_prev;
		logic [TMR_W-1:0] edge_cnt;
		logic [7:0]       shreg;
		logic             pre_found;
		logic [3:0]       data_cnt;
		logic             led1;
		logic             led2;
		logic             ledb;
		logic             valid;
	} oprc_state_t;

	oprc_state_t st_q;
	oprc_state_t st_d;

	logic [3:0]       btn_s;
	logic             batt_s;
	logic             rx_s;
	logic             signal_strength_indicator_s;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic             tmr_done;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_btn
			oprc_sync u_btn (
				.ref_clk (ref_clk),
				.rst     (rst),
				.clk_en  (clk_en),
				.rst_val (1'b1),
				.din     (button_n[g]),
				.dout    (btn_s[g])
			);
		end
	endgenerate

	oprc_sync u_batt (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.rst_val (1'b0),
		.din     (low_batt),
		.dout    (batt_s)
	);

	oprc_sync u_rx (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.rst_val (1'b0),
		.din     (rx_data),
		.dout    (rx_s)
	);

	oprc_sync u_signal_strength_indicator (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.rst_val (1'b0),
		.din     (signal_strength_indicator),
		.dout    (signal_strength_indicator_s)
	);

	oprc_bit_timer u_tmr (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.load    (tmr_load),
		.count   (tmr_count),
		.done    (tmr_done)
	);

	// Lowest pressed button wins when several fall together
	function automatic logic [1:0] oprc_pick(input logic [3:0] fell);
		if (fell[0]) begin
			oprc_pick = 2'h0;
		end else if (fell[1]) begin
			oprc_pick = 2'h1;
		end else if (fell[2]) begin
			oprc_pick = 2'h2;
		end else begin
			oprc_pick = 2'h3;
		end
	endfunction

	function automatic logic [TMR_W-1:0] oprc_on_time(input logic b);
		oprc_on_time = b ? TMR_W'(TWO_THIRD_CYC) : TMR_W'(THIRD_CYC);
	endfunction

	function automatic logic [TMR_W-1:0] oprc_off_time(input logic b);
		oprc_off_time = b ? TMR_W'(THIRD_CYC) : TMR_W'(TWO_THIRD_CYC);
	endfunction

	logic [3:0] fell;
	logic       rx_rise;
	logic       rx_fall;
	logic       edge_ok;
	logic       bit_val;
	logic [7:0] cand;
	logic [3:0] id_n;
	logic [3:0] bat_n;

	always_comb begin
		st_d = st_q;
		tmr_load = 1'b0;
		tmr_count = '0;
		fell = st_q.btn_prev & ~btn_s;
		st_d.btn_prev = btn_s;
		rx_rise = rx_s & ~st_q.rx_prev;
		rx_fall = ~rx_s & st_q.rx_prev;
		edge_ok = ~strength_check_en | signal_strength_indicator_s; // R21
		bit_val = 1'b0;
		cand = '0;
		id_n = '0;
		bat_n = '0;

		case (st_q.tx_st)
			TX_SLEEP: begin
				if (fell != 4'h0) begin // R11
					st_d.asleep = 1'b0;
					// Battery level caught at the press itself
					st_d.data_byte = {(batt_s ? BATT_LOW : BATT_OK), oprc_btn_code(oprc_pick(fell))}; // R4 R6 R7 R10
					st_d.frame = {PREAMBLE, 8'h00}; // R3
					st_d.bits_left = FRAME_BITS;
					st_d.reps_left = DATA_REPEATS; // R5
					st_d.tx_st = TX_NEXT;
				end
			end
			TX_NEXT: begin
				if (st_q.bits_left == 5'h00) begin
					if (st_q.reps_left == 3'h0) begin
						st_d.asleep = 1'b1;
						st_d.tx_st = TX_SLEEP;
					end else begin
						st_d.frame = {st_q.data_byte, 16'h0000}; // R5
						st_d.bits_left = 5'(BYTE_BITS);
						st_d.reps_left = st_q.reps_left - 3'h1;
					end
				end else begin
					st_d.cur_bit = st_q.frame[23]; // R23
					st_d.frame = {st_q.frame[22:0], 1'b0};
					st_d.bits_left = st_q.bits_left - 5'h01;
					st_d.carrier = 1'b1; // R22
					tmr_load = 1'b1;
					tmr_count = oprc_on_time(st_q.frame[23]); // R1 R2 R8 R9
					st_d.tx_st = TX_HIGH;
				end
			end
			TX_HIGH: begin
				if (tmr_done) begin
					st_d.carrier = 1'b0;
					tmr_load = 1'b1;
					tmr_count = oprc_off_time(st_q.cur_bit); // R8 R9
					st_d.tx_st = TX_LOW;
				end
			end
			TX_LOW: begin
				if (tmr_done) begin
					st_d.tx_st = TX_NEXT; // R8
				end
			end
			default: begin
				st_d.tx_st = TX_SLEEP;
				st_d.carrier = 1'b0;
			end
		endcase

		// Receiver runs regardless of transmit activity
		st_d.rx_prev = rx_s;
		if (rx_rise | rx_fall) begin // R12
			st_d.edge_cnt = '0; // R14
		end else if (st_q.edge_cnt != {TMR_W{1'b1}}) begin
			st_d.edge_cnt = st_q.edge_cnt + TMR_W'(1); // R13
		end

		if (rx_fall && edge_ok) begin // R14
			if (st_q.edge_cnt < TMR_W'(MIN_PULSE_CYC) || st_q.edge_cnt > TMR_W'(MAX_PULSE_CYC)) begin
				// Out-of-range pulse is noise: drop back to preamble hunting
				st_d.pre_found = 1'b0;
				st_d.data_cnt = '0;
				st_d.shreg = '0;
			end else begin
				bit_val = st_q.edge_cnt >= TMR_W'(SPLIT_CYC); // R15
				cand = {st_q.shreg[6:0], bit_val}; // R16 R23
				st_d.shreg = cand;
				if (!st_q.pre_found) begin
					if (cand == PRE_LOW) begin // R16
						st_d.pre_found = 1'b1;
						st_d.data_cnt = '0;
					end
				end else if (st_q.data_cnt == BYTE_BITS - 4'h1) begin // R17
					id_n = cand[3:0];
					bat_n = cand[7:4];
					st_d.pre_found = 1'b0;
					st_d.data_cnt = '0;
					st_d.shreg = '0; // R18
					if (bat_n == BATT_OK || bat_n == BATT_LOW) begin
						st_d.valid = 1'b1;
						st_d.ledb = (bat_n != BATT_OK); // R20 R6
						case (id_n) // R18 R7
							BTN0_CODE: begin
								st_d.led1 = 1'b0; // R19
								st_d.led2 = 1'b0;
							end
							BTN1_CODE: begin
								st_d.led1 = 1'b0;
								st_d.led2 = 1'b1;
							end
							BTN2_CODE: begin
								st_d.led1 = 1'b1;
								st_d.led2 = 1'b0;
							end
							BTN3_CODE: begin
								st_d.led1 = 1'b1;
								st_d.led2 = 1'b1;
							end
							default: begin
								st_d.valid = st_q.valid;
								st_d.ledb = st_q.ledb;
							end
						endcase
					end
				end else begin
					st_d.data_cnt = st_q.data_cnt + 4'h1; // R17
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= '0;
			st_q.tx_st <= TX_SLEEP;
			st_q.asleep <= 1'b1;
			st_q.btn_prev <= 4'hF;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign carrier_on = st_q.carrier;
	assign tx_asleep = st_q.asleep;
	assign led_first = st_q.led1;
	assign led_second = st_q.led2;
	assign led_low_batt = st_q.ledb;
	assign code_valid = st_q.valid;
endmodule
`default_nettype wire

// ==== oprc_codec_props.sv ====
// Checker for oprc_codec: wake, carrier keying widths and indicator rules.
// Assumes it is bound to oprc_codec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module oprc_codec_chk
	import oprc_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic [3:0] button_n,
	input wire logic       carrier_on,
	input wire logic       tx_asleep,
	input wire logic       led_first,
	input wire logic       led_second,
	input wire logic       led_low_batt,
	input wire logic       code_valid
);
	logic [17:0] on_q;
	logic [17:0] off_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Widths count only enabled cycles, since a frozen clock stretches the keying
	always_ff @(posedge ref_clk) begin
		if (rst || !carrier_on)
			on_q <= '0;
		else if (clk_en)
			on_q <= on_q + 18'h1;
		if (rst || carrier_on || tx_asleep)
			off_q <= '0;
		else if (clk_en)
			off_q <= off_q + 18'h1;
	end
	property p_rst_idle;
		@(posedge ref_clk) disable iff (1'b0) rst |=> tx_asleep && !carrier_on && !code_valid;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
	property p_wake;
		$fell(&button_n) && tx_asleep && !$past(rst) |-> ##[1:10] !tx_asleep;
	endproperty
	a_wake: assert property (p_wake) else $error("sender did not wake on press");
	property p_asleep_off;
		tx_asleep |-> !carrier_on;
	endproperty
	a_asleep_off: assert property (p_asleep_off) else $error("carrier keyed while asleep");
	property p_key_start;
		$fell(tx_asleep) && !$past(rst) |-> ##[1:6] carrier_on;
	endproperty
	a_key_start: assert property (p_key_start) else $error("carrier did not start");
	property p_on_len;
		$fell(carrier_on) && !$past(rst) |-> (on_q >= THIRD_CYC && on_q <= THIRD_CYC + 2)
			|| (on_q >= TWO_THIRD_CYC && on_q <= TWO_THIRD_CYC + 2);
	endproperty
	a_on_len: assert property (p_on_len) else $error("carrier on time wrong");
	property p_off_len;
		$rose(carrier_on) && off_q > 18'h10 |-> (off_q >= THIRD_CYC && off_q <= THIRD_CYC + 5)
			|| (off_q >= TWO_THIRD_CYC && off_q <= TWO_THIRD_CYC + 5);
	endproperty
	a_off_len: assert property (p_off_len) else $error("carrier off time wrong");
	property p_led_gate;
		!code_valid |-> !led_first && !led_second && !led_low_batt;
	endproperty
	a_led_gate: assert property (p_led_gate) else $error("indicator lit without a code");
	property p_valid_sticky;
		code_valid |=> code_valid;
	endproperty
	a_valid_sticky: assert property (p_valid_sticky) else $error("valid status dropped");
endmodule
`default_nettype wire

// ==== oprc_rf_model.sv ====
// Far-side model: demodulated data line and strength comparator of the RF receiver.
// Assumes the codec clock; the testbench starts bytes through send_byte after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module oprc_rf_model
	import oprc_pkg::*;
(
	input  wire logic ref_clk,
	output var  logic rx_data,
	output var  logic signal_strength_indicator
);
	// Margins keep pulses clear of the long/short split and the noise floor
	localparam int HI_ONE  = SPLIT_CYC + (SPLIT_CYC / 3);
	localparam int HI_ZERO = (MIN_PULSE_CYC + SPLIT_CYC) / 2;
	localparam int LO_GAP  = 500;
	initial begin
		rx_data = 1'b0;
		signal_strength_indicator = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic send_byte(input logic [7:0] v);
		signal_strength_indicator <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			rx_data <= 1'b1;
			hold(v[i] ? HI_ONE : HI_ZERO);
			rx_data <= 1'b0;
			hold(LO_GAP);
		end
		signal_strength_indicator <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Testbench for oprc_codec: wakes the sender and times one keyed bit, then decodes frames.
// Assumes the codec, its checker and the receiver model are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb
	import oprc_pkg::*;
;
	logic       ref_clk;
	logic       rst;
	logic       clk_en;
	logic       low_batt;
	logic       strength_check_en;
	logic [3:0] button_n;
	logic       rx_data;
	logic       signal_strength_indicator;
	logic       carrier_on;
	logic       tx_asleep;
	logic       led_first;
	logic       led_second;
	logic       led_low_batt;
	logic       code_valid;
	int         miscompares;
	int         cmp_count;
	oprc_codec dut_u (.ref_clk, .rst, .clk_en, .button_n, .low_batt, .rx_data, .signal_strength_indicator,
		.strength_check_en, .carrier_on, .tx_asleep, .led_first, .led_second, .led_low_batt, .code_valid);
	oprc_rf_model rf_u (.ref_clk, .rx_data, .signal_strength_indicator);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic give_up();
		miscompares++;
		$display("Error at %0t: wait ran out", $time);
		finish_test();
	endtask
	// Counts cycles while the chosen output keeps level v; sampled on falling edges to avoid races
	task automatic span(input logic sel, input logic v, output int k);
		k = 0;
		while ((sel ? tx_asleep : carrier_on) === v) begin
			@(negedge ref_clk);
			k++;
			if (k > BIT_CYC)
				give_up();
		end
	endtask
	task automatic test_tx_key();
		int k;
		@(negedge ref_clk);
		check({30'h0, tx_asleep, carrier_on}, 32'h2);
		@(posedge ref_clk);
		button_n <= 4'hB;
		low_batt <= 1'b1;
		span(1'b1, 1'b1, k);
		check(32'(k <= 12), 32'h1);
		span(1'b0, 1'b0, k);
		check(32'(k <= 6), 32'h1);
		span(1'b0, 1'b1, k);
		check(32'(k >= TWO_THIRD_CYC && k <= TWO_THIRD_CYC + 2), 32'h1);
		span(1'b0, 1'b0, k);
		check(32'(k >= THIRD_CYC && k <= THIRD_CYC + 5), 32'h1);
		check({31'h0, tx_asleep}, 32'h0);
		@(posedge ref_clk);
		button_n <= 4'hF;
		$display("test_tx_key done");
	endtask
	task automatic test_rx_frame();
		@(posedge ref_clk);
		strength_check_en <= 1'b1;
		@(posedge ref_clk);
		rf_u.send_byte(PRE_LOW);
		rf_u.send_byte({BATT_LOW, BTN1_CODE});
		@(negedge ref_clk);
		check({29'h0, led_first, led_second, led_low_batt}, 32'h3);
		check({31'h0, code_valid}, 32'h1);
		@(posedge ref_clk);
		rf_u.send_byte(PRE_LOW);
		rf_u.send_byte(8'h05);
		@(negedge ref_clk);
		check({28'h0, code_valid, led_first, led_second, led_low_batt}, 32'hB);
		$display("test_rx_frame done");
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		low_batt = 1'b0;
		strength_check_en = 1'b0;
		button_n = 4'hF;
		miscompares = 0;
		cmp_count = 0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		test_tx_key();
		test_rx_frame();
		finish_test();
	end
endmodule
bind oprc_codec oprc_codec_chk chk_u (.ref_clk, .rst, .clk_en, .button_n, .carrier_on, .tx_asleep,
	.led_first, .led_second, .led_low_batt, .code_valid);
`default_nettype wire
